// [inc/afe_pkg.sv]
// Shared constants for the converter front-end register slice
package afe_pkg;
  localparam logic [7:0] AFE_OFS_GAIN_CAL_HIGH = 8'hD6;
  localparam logic [7:0] AFE_OFS_CHANNEL_SELECT = 8'hD7;
  localparam logic [7:0] AFE_OFS_IRQ_CONTROL_FLAGS = 8'hD8;
  localparam logic [7:0] AFE_OFS_RESULT_LOW = 8'hD9;
  localparam logic [7:0] AFE_OFS_RESULT_MID = 8'hDA;
  localparam logic [7:0] AFE_OFS_RESULT_HIGH = 8'hDB;
  localparam logic [7:0] AFE_OFS_FRONT_END_CONTROL = 8'hDC;
  localparam logic [7:0] AFE_RST_GAIN_CAL_HIGH = 8'h5F;
  localparam logic [7:0] AFE_RST_CHANNEL_SELECT = 8'h01;
  localparam logic [7:0] AFE_RST_IRQ_CONTROL_FLAGS = 8'h40;
  localparam logic [7:0] AFE_RST_RESULT = 8'h00;
  localparam logic [7:0] AFE_RST_FRONT_END_CONTROL = 8'h30;
  localparam logic [7:0] AFE_UNMAPPED_READ = 8'h00;
  localparam int AFE_BIT_AUX_IRQ_ENABLE = 5;
  localparam int AFE_BIT_AUX_IRQ_FLAG = 4;
  localparam int AFE_BIT_WATCHDOG_IRQ_FLAG = 3;
  localparam int AFE_BIT_OPEN_CIRCUIT_DETECT = 6;
  localparam int AFE_BIT_REFERENCE_ENABLE = 5;
  localparam int AFE_BIT_REFERENCE_LEVEL_SELECT = 4;
  localparam int AFE_BIT_BUFFER_ENABLE = 3;
  localparam logic [3:0] AFE_CODE_SHARED_RETURN = 4'h8;
  localparam logic [3:0] AFE_CODE_TEMP_SENSOR = 4'hF;
  localparam logic [3:0] AFE_CODE_REDUCED_LO = 4'h6;
endpackage : afe_pkg

// [inc/afe_sfr_if.sv]
// Special-function register bus between the core and the front-end slice
`timescale 1ns/1ps
interface afe_sfr_if (
  input wire logic clk_i,
  input wire logic nrst_i
);
  logic [7:0] addr;
  logic wr;
  logic rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic aux_irq;
  logic wdt_irq;
  modport core (input clk_i, nrst_i, rdata, aux_irq, wdt_irq, output addr, wr, rd, wdata);
  modport sfr (input clk_i, nrst_i, addr, wr, rd, wdata, output rdata, aux_irq, wdt_irq);
endinterface : afe_sfr_if

// [verilog/afe_chan_decode.sv]
// Decodes the channel selector nibbles into analog switch enables
`timescale 1ns/1ps
module afe_chan_decode
  import afe_pkg::*;
#(
  parameter bit REDUCED_PINS = 1'b0
) (
  input wire logic [3:0] positive_channel_code_i,
  input wire logic [3:0] negative_channel_code_i,
  output logic [7:0] pos_pin_o,
  output logic pos_common_o,
  output logic pos_reference_low_o,
  output logic [7:0] neg_pin_o,
  output logic neg_common_o,
  output logic temp_sensor_o
);
  logic temp_sel;
  logic pos_tied;
  assign temp_sel = (positive_channel_code_i == AFE_CODE_TEMP_SENSOR) &&
                    (negative_channel_code_i == AFE_CODE_TEMP_SENSOR);
  assign pos_tied = REDUCED_PINS && !positive_channel_code_i[3] &&
                    (positive_channel_code_i[2:0] >= AFE_CODE_REDUCED_LO[2:0]);
  always_comb begin
    pos_pin_o = 8'h00;
    neg_pin_o = 8'h00;
    if (!positive_channel_code_i[3] && !pos_tied) begin
      pos_pin_o[positive_channel_code_i[2:0]] = 1'b1;
    end
    if (!negative_channel_code_i[3]) begin
      neg_pin_o[negative_channel_code_i[2:0]] = 1'b1;
    end
  end
  assign pos_common_o = (positive_channel_code_i == AFE_CODE_SHARED_RETURN);
  assign neg_common_o = (negative_channel_code_i == AFE_CODE_SHARED_RETURN);
  assign pos_reference_low_o = pos_tied;
  assign temp_sensor_o = temp_sel;
endmodule : afe_chan_decode

// [verilog/afe_regs.sv]
// Front-end register slice: the device end of the register bus
// How it works
// - Calibration completion loads gain high byte; reset 5Fh
// - Gain high byte fully software readable and writable
// - Upper selector nibble picks positive input
// - Lower nibble picks negative input; reset 01h
// - Temperature sensor needs whole selector at FFh
// - Reduced pins: positive codes 6,7 tie reference-low
// - Enable bit gates merged auxiliary interrupt; reset off
// - Software clears aux flag after its source
// - Software writing aux flag one raises request
// - Watchdog flag sticky; software set raises interrupt
// - Watchdog expiry interrupts only with reset disabled
// - Reading result low clears converter interrupt source
// - Result as three read-only bytes
// - Sixteen-bit variant high byte is sign/zero fill
// - Open-circuit detect drives burnout current sources
// - Reference enable bit; resets on
// - Reference level bit: 1.25V or 2.5V; resets high
// - Buffer enable bit; resets off
// - Gain field gives two to the code
// - Front-end control resets to 30h
// - Result coded by polarity: two's complement or binary
`timescale 1ns/1ps
module afe_regs
  import afe_pkg::*;
#(
  parameter bit RESULT_16BIT = 1'b0,
  parameter bit REDUCED_PINS = 1'b0
) (
  afe_sfr_if.sfr bus,
  input wire logic cal_done_i,
  input wire logic [23:0] cal_gain_word_i,
  input wire logic result_valid_i,
  input wire logic [23:0] result_word_i,
  input wire logic result_polarity_i,
  input wire logic aux_source_i,
  input wire logic watchdog_expired_i,
  input wire logic watchdog_irq_enable_i,
  input wire logic hardware_config_zero_reset_disable_i,
  output logic [7:0] pos_pin_o,
  output logic pos_common_o,
  output logic pos_reference_low_o,
  output logic [7:0] neg_pin_o,
  output logic neg_common_o,
  output logic temp_sensor_o,
  output logic open_circuit_detect_o,
  output logic reference_enable_o,
  output logic reference_level_select_o,
  output logic buffer_enable_o,
  output logic [2:0] gain_code_o,
  output logic [7:0] gain_factor_o,
  output logic converter_irq_pending_o,
  output logic watchdog_reset_o
);
  logic [7:0] gain_cal_high_r, gain_cal_high_nxt;
  logic [7:0] channel_select_r, channel_select_nxt;
  logic aux_irq_enable_r, aux_irq_enable_nxt;
  logic aux_irq_flag_r, aux_irq_flag_nxt;
  logic watchdog_irq_flag_r, watchdog_irq_flag_nxt;
  logic [23:0] result_r, result_nxt;
  logic [7:0] front_end_control_r, front_end_control_nxt;
  logic conv_pending_r, conv_pending_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic aux_irq_r, aux_irq_nxt;
  logic wdt_irq_r, wdt_irq_nxt;
  logic wdt_reset_r, wdt_reset_nxt;
  logic [7:0] pos_pin_r, neg_pin_r;
  logic pos_common_r, neg_common_r, pos_ref_low_r, temp_r;
  logic [7:0] gain_factor_r;
  logic [7:0] dec_pos_pin, dec_neg_pin;
  logic dec_pos_common, dec_neg_common, dec_pos_ref_low, dec_temp;
  logic [7:0] irq_view;
  logic [7:0] high_view;

  afe_chan_decode #(.REDUCED_PINS(REDUCED_PINS)) u_decode (
    .positive_channel_code_i(channel_select_r[7:4]),
    .negative_channel_code_i(channel_select_r[3:0]),
    .pos_pin_o(dec_pos_pin),
    .pos_common_o(dec_pos_common),
    .pos_reference_low_o(dec_pos_ref_low),
    .neg_pin_o(dec_neg_pin),
    .neg_common_o(dec_neg_common),
    .temp_sensor_o(dec_temp)
  );

  // Interrupt control view with constant bits fixed
  always_comb begin
    irq_view = AFE_RST_IRQ_CONTROL_FLAGS;
    irq_view[AFE_BIT_AUX_IRQ_ENABLE] = aux_irq_enable_r;
    irq_view[AFE_BIT_AUX_IRQ_FLAG] = aux_irq_flag_r;
    irq_view[AFE_BIT_WATCHDOG_IRQ_FLAG] = watchdog_irq_flag_r;
  end

  // Sixteen-bit variant fills the top byte from the sign, or with zeros when result_polarity_i is set
  always_comb begin
    if (RESULT_16BIT) begin
      high_view = (!result_polarity_i && result_r[15]) ? 8'hFF : 8'h00;
    end else begin
      high_view = result_r[23:16];
    end
  end

  always_comb begin
    gain_cal_high_nxt = gain_cal_high_r;
    channel_select_nxt = channel_select_r;
    aux_irq_enable_nxt = aux_irq_enable_r;
    aux_irq_flag_nxt = aux_irq_flag_r;
    watchdog_irq_flag_nxt = watchdog_irq_flag_r;
    result_nxt = result_r;
    front_end_control_nxt = front_end_control_r;
    conv_pending_nxt = conv_pending_r;
    rdata_nxt = rdata_r;
    wdt_reset_nxt = 1'b0;
    if (bus.wr) begin
      unique case (bus.addr)
        AFE_OFS_GAIN_CAL_HIGH: gain_cal_high_nxt = bus.wdata;
        AFE_OFS_CHANNEL_SELECT: channel_select_nxt = bus.wdata;
        AFE_OFS_IRQ_CONTROL_FLAGS: begin
          aux_irq_enable_nxt = bus.wdata[AFE_BIT_AUX_IRQ_ENABLE];
          aux_irq_flag_nxt = bus.wdata[AFE_BIT_AUX_IRQ_FLAG];
          watchdog_irq_flag_nxt = bus.wdata[AFE_BIT_WATCHDOG_IRQ_FLAG];
        end
        AFE_OFS_FRONT_END_CONTROL: front_end_control_nxt = bus.wdata;
        default: ;
      endcase
    end
    if (bus.rd) begin
      unique case (bus.addr)
        AFE_OFS_GAIN_CAL_HIGH: rdata_nxt = gain_cal_high_r;
        AFE_OFS_CHANNEL_SELECT: rdata_nxt = channel_select_r;
        AFE_OFS_IRQ_CONTROL_FLAGS: rdata_nxt = irq_view;
        AFE_OFS_RESULT_LOW: begin
          rdata_nxt = result_r[7:0];
          conv_pending_nxt = 1'b0;
        end
        AFE_OFS_RESULT_MID: rdata_nxt = result_r[15:8];
        AFE_OFS_RESULT_HIGH: rdata_nxt = high_view;
        AFE_OFS_FRONT_END_CONTROL: rdata_nxt = front_end_control_r;
        default: rdata_nxt = AFE_UNMAPPED_READ;
      endcase
    end
    // Hardware events override a same-cycle software clear
    if (cal_done_i) begin
      gain_cal_high_nxt = cal_gain_word_i[23:16];
    end
    if (result_valid_i) begin
      result_nxt = result_word_i;
      conv_pending_nxt = 1'b1;
    end
    if (aux_source_i || conv_pending_r) begin
      aux_irq_flag_nxt = 1'b1;
    end
    if (watchdog_expired_i) begin
      if (hardware_config_zero_reset_disable_i) begin
        watchdog_irq_flag_nxt = 1'b1;
      end else begin
        wdt_reset_nxt = 1'b1;
      end
    end
  end

  assign aux_irq_nxt = aux_irq_enable_r && aux_irq_flag_r;
  assign wdt_irq_nxt = watchdog_irq_enable_i && watchdog_irq_flag_r;

  always_ff @(posedge bus.clk_i or negedge bus.nrst_i) begin
    if (!bus.nrst_i) begin
      gain_cal_high_r <= AFE_RST_GAIN_CAL_HIGH;
      channel_select_r <= AFE_RST_CHANNEL_SELECT;
      aux_irq_enable_r <= 1'b0;
      aux_irq_flag_r <= 1'b0;
      watchdog_irq_flag_r <= 1'b0;
      result_r <= {3{AFE_RST_RESULT}};
      front_end_control_r <= AFE_RST_FRONT_END_CONTROL;
      conv_pending_r <= 1'b0;
      rdata_r <= AFE_UNMAPPED_READ;
      aux_irq_r <= 1'b0;
      wdt_irq_r <= 1'b0;
      wdt_reset_r <= 1'b0;
    end else begin
      gain_cal_high_r <= gain_cal_high_nxt;
      channel_select_r <= channel_select_nxt;
      aux_irq_enable_r <= aux_irq_enable_nxt;
      aux_irq_flag_r <= aux_irq_flag_nxt;
      watchdog_irq_flag_r <= watchdog_irq_flag_nxt;
      result_r <= result_nxt;
      front_end_control_r <= front_end_control_nxt;
      conv_pending_r <= conv_pending_nxt;
      rdata_r <= rdata_nxt;
      aux_irq_r <= aux_irq_nxt;
      wdt_irq_r <= wdt_irq_nxt;
      wdt_reset_r <= wdt_reset_nxt;
    end
  end

  // Analog drive registers, one clock after the stored value
  always_ff @(posedge bus.clk_i or negedge bus.nrst_i) begin
    if (!bus.nrst_i) begin
      pos_pin_r <= 8'h01;
      neg_pin_r <= 8'h02;
      pos_common_r <= 1'b0;
      neg_common_r <= 1'b0;
      pos_ref_low_r <= 1'b0;
      temp_r <= 1'b0;
      gain_factor_r <= 8'h01;
    end else begin
      pos_pin_r <= dec_pos_pin;
      neg_pin_r <= dec_neg_pin;
      pos_common_r <= dec_pos_common;
      neg_common_r <= dec_neg_common;
      pos_ref_low_r <= dec_pos_ref_low;
      temp_r <= dec_temp;
      gain_factor_r <= 8'h01 << front_end_control_r[2:0];
    end
  end

  assign bus.rdata = rdata_r;
  assign bus.aux_irq = aux_irq_r;
  assign bus.wdt_irq = wdt_irq_r;
  assign pos_pin_o = pos_pin_r;
  assign neg_pin_o = neg_pin_r;
  assign pos_common_o = pos_common_r;
  assign neg_common_o = neg_common_r;
  assign pos_reference_low_o = pos_ref_low_r;
  assign temp_sensor_o = temp_r;
  // Burnout sources only useful with buffer on; software must set both
  assign open_circuit_detect_o = front_end_control_r[AFE_BIT_OPEN_CIRCUIT_DETECT];
  assign reference_enable_o = front_end_control_r[AFE_BIT_REFERENCE_ENABLE];
  assign reference_level_select_o = front_end_control_r[AFE_BIT_REFERENCE_LEVEL_SELECT];
  assign buffer_enable_o = front_end_control_r[AFE_BIT_BUFFER_ENABLE];
  assign gain_code_o = front_end_control_r[2:0];
  assign gain_factor_o = gain_factor_r;
  assign converter_irq_pending_o = conv_pending_r;
  assign watchdog_reset_o = wdt_reset_r;
endmodule : afe_regs

// [verilog/afe_core_port.sv]
// Core end of the register bus: turns user requests into bus cycles
`timescale 1ns/1ps
module afe_core_port
  import afe_pkg::*;
(
  afe_sfr_if.core bus,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [7:0] req_addr_i,
  input wire logic [7:0] req_wdata_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o,
  output logic aux_irq_o,
  output logic wdt_irq_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_STROBE, ST_CAPTURE} afe_core_state_t;
  afe_core_state_t state_r, state_nxt;
  logic [7:0] addr_r, addr_nxt, wdata_r, wdata_nxt, data_r, data_nxt;
  logic wr_r, wr_nxt, rd_r, rd_nxt, ready_r, ready_nxt, rsp_r, rsp_nxt;
  logic aux_r, wdt_r;

  always_comb begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    data_nxt = data_r;
    wr_nxt = 1'b0;
    rd_nxt = 1'b0;
    rsp_nxt = 1'b0;
    ready_nxt = ready_r;
    unique case (state_r)
      ST_IDLE: begin
        if (req_valid_i) begin
          addr_nxt = req_addr_i;
          wdata_nxt = req_wdata_i;
          wr_nxt = req_write_i;
          rd_nxt = !req_write_i;
          ready_nxt = 1'b0;
          state_nxt = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (!wr_r) begin
          state_nxt = ST_CAPTURE;
        end else begin
          rsp_nxt = 1'b1;
          ready_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      ST_CAPTURE: begin
        data_nxt = bus.rdata;
        rsp_nxt = 1'b1;
        ready_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge bus.clk_i or negedge bus.nrst_i) begin
    if (!bus.nrst_i) begin
      state_r <= ST_IDLE;
      addr_r <= 8'h00;
      wdata_r <= 8'h00;
      data_r <= 8'h00;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      rsp_r <= 1'b0;
      ready_r <= 1'b1;
      aux_r <= 1'b0;
      wdt_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      data_r <= data_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      rsp_r <= rsp_nxt;
      ready_r <= ready_nxt;
      aux_r <= bus.aux_irq;
      wdt_r <= bus.wdt_irq;
    end
  end

  assign bus.addr = addr_r;
  assign bus.wdata = wdata_r;
  assign bus.wr = wr_r;
  assign bus.rd = rd_r;
  assign req_ready_o = ready_r;
  assign rsp_valid_o = rsp_r;
  assign rsp_data_o = data_r;
  assign aux_irq_o = aux_r;
  assign wdt_irq_o = wdt_r;
endmodule : afe_core_port

// [testbench/afe_sfr_chk.sv]
// Bus-level checker for the front-end register slice
`timescale 1ns/1ps
module afe_sfr_chk
  import afe_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic aux_irq,
  input wire logic wdt_irq
);
  logic [7:0] chan_r, chan_nxt, fe_r, fe_nxt;
  logic [2:0] irq_r, irq_nxt;

  // Shadows of what software last wrote
  always_comb begin
    chan_nxt = chan_r;
    fe_nxt = fe_r;
    irq_nxt = irq_r;
    if (wr && addr == AFE_OFS_CHANNEL_SELECT) chan_nxt = wdata;
    if (wr && addr == AFE_OFS_FRONT_END_CONTROL) fe_nxt = wdata;
    if (wr && addr == AFE_OFS_IRQ_CONTROL_FLAGS) irq_nxt = wdata[5:3];
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chan_r <= AFE_RST_CHANNEL_SELECT;
      fe_r <= AFE_RST_FRONT_END_CONTROL;
      irq_r <= 3'h0;
    end else begin
      chan_r <= chan_nxt;
      fe_r <= fe_nxt;
      irq_r <= irq_nxt;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_rd(a);
    rd && addr == a;
  endsequence
  sequence s_wr_aux_set;
    wr && addr == AFE_OFS_IRQ_CONTROL_FLAGS && wdata[5] && wdata[4];
  endsequence

  chk_irq_fixed_bits:
    assert property (s_rd(AFE_OFS_IRQ_CONTROL_FLAGS) |=> rdata[7:6] == 2'b01 && rdata[2:0] == 3'h0)
    else $error("irq control fixed bits wrong");
  chk_chan_readback:
    assert property (s_rd(AFE_OFS_CHANNEL_SELECT) |=> rdata == $past(chan_r))
    else $error("channel select readback wrong");
  chk_fe_readback:
    assert property (s_rd(AFE_OFS_FRONT_END_CONTROL) |=> rdata == $past(fe_r))
    else $error("front end control readback wrong");
  chk_aux_enable_read:
    assert property (s_rd(AFE_OFS_IRQ_CONTROL_FLAGS) |=> rdata[5] == $past(irq_r[2]))
    else $error("aux enable readback wrong");
  chk_aux_gated:
    assert property (aux_irq |-> irq_r[2] || $past(irq_r[2]))
    else $error("aux interrupt while disabled");
  chk_aux_sw_raise:
    assert property (s_wr_aux_set |-> ##[1:3] aux_irq)
    else $error("aux interrupt not raised by software set");
  chk_wdt_sticky:
    assert property (rd && addr == AFE_OFS_IRQ_CONTROL_FLAGS && irq_r[0] |=> rdata[3])
    else $error("watchdog flag lost");
  chk_aux_sticky:
    assert property (rd && addr == AFE_OFS_IRQ_CONTROL_FLAGS && irq_r[1] |=> rdata[4])
    else $error("aux flag lost");
  chk_rdata_holds:
    assert property (!rd |=> $stable(rdata))
    else $error("read data changed without read");
endmodule : afe_sfr_chk

// [testbench/testbench.sv]
// Testbench joining core port and register slice over the register bus
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module testbench
  import afe_pkg::*;
;
  logic clk_i, nrst_i, req_valid_i, req_write_i, req_ready_o, rsp_valid_o, aux_irq_o, wdt_irq_o;
  logic [7:0] req_addr_i, req_wdata_i, rsp_data_o, pos_pin_o, neg_pin_o, gain_factor_o;
  logic cal_done_i, result_valid_i, result_polarity_i, aux_source_i, watchdog_expired_i;
  logic watchdog_irq_enable_i, hardware_config_zero_reset_disable_i;
  logic [23:0] cal_gain_word_i, result_word_i;
  logic pos_common_o, pos_reference_low_o, neg_common_o, temp_sensor_o, open_circuit_detect_o;
  logic reference_enable_o, reference_level_select_o, buffer_enable_o;
  logic converter_irq_pending_o, watchdog_reset_o;
  logic [2:0] gain_code_o;
  int num_errors, num_checks;

  afe_sfr_if bus_if (.clk_i, .nrst_i);
  afe_core_port afe_core_port_inst (.bus(bus_if), .req_valid_i, .req_write_i, .req_addr_i,
    .req_wdata_i, .req_ready_o, .rsp_valid_o, .rsp_data_o, .aux_irq_o, .wdt_irq_o);
  afe_regs #(.REDUCED_PINS(1'b1)) afe_regs_inst (.bus(bus_if), .cal_done_i, .cal_gain_word_i,
    .result_valid_i,
    .result_word_i, .result_polarity_i, .aux_source_i, .watchdog_expired_i,
    .watchdog_irq_enable_i, .hardware_config_zero_reset_disable_i, .pos_pin_o, .pos_common_o,
    .pos_reference_low_o, .neg_pin_o, .neg_common_o, .temp_sensor_o, .open_circuit_detect_o,
    .reference_enable_o, .reference_level_select_o, .buffer_enable_o, .gain_code_o,
    .gain_factor_o, .converter_irq_pending_o, .watchdog_reset_o);
  afe_sfr_chk afe_sfr_chk_inst (.clk_i, .nrst_i, .addr(bus_if.addr), .wr(bus_if.wr),
    .rd(bus_if.rd), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .aux_irq(bus_if.aux_irq),
    .wdt_irq(bus_if.wdt_irq));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task wrap_up;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_write_i <= w;
    req_addr_i <= a;
    req_wdata_i <= d;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (rsp_valid_o !== 1'b1 && n < 8);
    if (rsp_valid_o !== 1'b1) begin
      num_errors++;
      $display("mismatch bus response expected 1 seen 0");
      wrap_up;
    end
    q = rsp_data_o;
    `CHK("ready", 1'b1, req_ready_o)
  endtask : xfer

  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] a, e);
    logic [7:0] q;
    xfer(1'b0, a, 8'h00, q);
    `CHK(nm, e, q)
  endtask : rd_chk

  task settle;
    @(posedge clk_i);
    #1;
  endtask : settle

  task t_reset;
    logic [7:0] ex [7];
    ex = '{AFE_RST_GAIN_CAL_HIGH, AFE_RST_CHANNEL_SELECT, AFE_RST_IRQ_CONTROL_FLAGS,
      AFE_RST_RESULT, AFE_RST_RESULT, AFE_RST_RESULT, AFE_RST_FRONT_END_CONTROL};
    `CHK("pins", 16'h0201, {neg_pin_o, pos_pin_o})
    `CHK("fe bits", 4'h6, {open_circuit_detect_o, reference_enable_o,
      reference_level_select_o, buffer_enable_o})
    `CHK("gain", 8'h01, gain_factor_o)
    for (int i = 0; i < 7; i++) rd_chk("reset", AFE_OFS_GAIN_CAL_HIGH + 8'(i), ex[i]);
    rd_chk("unmapped", 8'hE0, AFE_UNMAPPED_READ);
  endtask : t_reset

  task t_gain;
    wr(AFE_OFS_GAIN_CAL_HIGH, 8'hA5);
    rd_chk("gain cal sw", AFE_OFS_GAIN_CAL_HIGH, 8'hA5);
    @(posedge clk_i);
    cal_gain_word_i <= 24'hC3_1234;
    cal_done_i <= 1'b1;
    @(posedge clk_i);
    cal_done_i <= 1'b0;
    rd_chk("gain cal hw", AFE_OFS_GAIN_CAL_HIGH, 8'hC3);
  endtask : t_gain

  task t_chan;
    logic [3:0] c;
    for (int i = 0; i <= 8; i++) begin
      c = 4'(i);
      wr(AFE_OFS_CHANNEL_SELECT, {c, 4'h8 - c});
      settle;
      `CHK("pos pin", (i < 6) ? 8'h01 << i : 8'h00, pos_pin_o)
      `CHK("ref low", i == 6 || i == 7, pos_reference_low_o)
      `CHK("neg pin", (i > 0) ? 8'h01 << (8 - i) : 8'h00, neg_pin_o)
      `CHK("common", {i == 8, i == 0}, {pos_common_o, neg_common_o})
    end
    wr(AFE_OFS_CHANNEL_SELECT, 8'hFF);
    settle;
    `CHK("temp", 1'b1, temp_sensor_o)
    wr(AFE_OFS_CHANNEL_SELECT, 8'hF1);
    settle;
    `CHK("temp half", 1'b0, temp_sensor_o)
  endtask : t_chan

  task t_fe;
    logic [7:0] v;
    for (int g = 0; g < 8; g++) begin
      v = {1'b0, g[0], ~g[0], g[1], g[2], 3'(g)};
      wr(AFE_OFS_FRONT_END_CONTROL, v);
      settle;
      `CHK("gain", 8'h01 << g, gain_factor_o)
      `CHK("gain code", 3'(g), gain_code_o)
      `CHK("fe bits", v[6:3], {open_circuit_detect_o, reference_enable_o,
        reference_level_select_o, buffer_enable_o})
      rd_chk("fe read", AFE_OFS_FRONT_END_CONTROL, v);
    end
  endtask : t_fe

  task t_irq;
    wr(AFE_OFS_IRQ_CONTROL_FLAGS, 8'hFF);
    rd_chk("irq all", AFE_OFS_IRQ_CONTROL_FLAGS, 8'h78);
    `CHK("irqs", 2'b11, {aux_irq_o, wdt_irq_o})
    wr(AFE_OFS_IRQ_CONTROL_FLAGS, 8'h00);
    rd_chk("irq clear", AFE_OFS_IRQ_CONTROL_FLAGS, 8'h40);
    `CHK("irqs off", 2'b00, {aux_irq_o, wdt_irq_o})
    @(posedge clk_i);
    aux_source_i <= 1'b1;
    rd_chk("aux src", AFE_OFS_IRQ_CONTROL_FLAGS, 8'h50);
    `CHK("aux masked", 1'b0, aux_irq_o)
    wr(AFE_OFS_IRQ_CONTROL_FLAGS, 8'h20);
    rd_chk("aux again", AFE_OFS_IRQ_CONTROL_FLAGS, 8'h70);
    `CHK("aux on", 1'b1, aux_irq_o)
    @(posedge clk_i);
    aux_source_i <= 1'b0;
    wr(AFE_OFS_IRQ_CONTROL_FLAGS, 8'h20);
    rd_chk("aux done", AFE_OFS_IRQ_CONTROL_FLAGS, 8'h60);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      hardware_config_zero_reset_disable_i <= k[0];
      watchdog_expired_i <= 1'b1;
      @(posedge clk_i);
      watchdog_expired_i <= 1'b0;
      #1;
      `CHK("wd reset", k == 0, watchdog_reset_o)
      rd_chk("wd flag", AFE_OFS_IRQ_CONTROL_FLAGS, (k == 0) ? 8'h60 : 8'h68);
    end
    `CHK("wdt irq", 1'b1, wdt_irq_o)
    @(posedge clk_i);
    watchdog_irq_enable_i <= 1'b0;
    repeat (3) settle;
    `CHK("wdt masked", 1'b0, wdt_irq_o)
    @(posedge clk_i);
    watchdog_irq_enable_i <= 1'b1;
    wr(AFE_OFS_IRQ_CONTROL_FLAGS, 8'h00);
  endtask : t_irq

  task t_result;
    @(posedge clk_i);
    result_word_i <= 24'h80_1234;
    result_valid_i <= 1'b1;
    @(posedge clk_i);
    result_valid_i <= 1'b0;
    settle;
    `CHK("pending", 1'b1, converter_irq_pending_o)
    wr(AFE_OFS_RESULT_LOW, 8'hFF);
    rd_chk("res mid", AFE_OFS_RESULT_MID, 8'h12);
    rd_chk("res high", AFE_OFS_RESULT_HIGH, 8'h80);
    `CHK("pending held", 1'b1, converter_irq_pending_o)
    rd_chk("res low", AFE_OFS_RESULT_LOW, 8'h34);
    `CHK("pending gone", 1'b0, converter_irq_pending_o)
    rd_chk("aux from adc", AFE_OFS_IRQ_CONTROL_FLAGS, 8'h50);
    wr(AFE_OFS_IRQ_CONTROL_FLAGS, 8'h00);
    rd_chk("aux retired", AFE_OFS_IRQ_CONTROL_FLAGS, 8'h40);
  endtask : t_result

  initial begin
    num_errors = 0;
    num_checks = 0;
    nrst_i = 1'b0;
    {req_valid_i, req_write_i, req_addr_i, req_wdata_i} = '0;
    {cal_done_i, result_valid_i, result_polarity_i, aux_source_i, watchdog_expired_i} = '0;
    {cal_gain_word_i, result_word_i, hardware_config_zero_reset_disable_i} = '0;
    watchdog_irq_enable_i = 1'b1;
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    settle;
    t_reset;
    t_gain;
    t_chan;
    t_fe;
    t_irq;
    t_result;
    wrap_up;
  end
endmodule : testbench
